// [verilog/ivg_pkg.sv]
`default_nettype none
package ivg_pkg;
  // program word address width and slot spacing
  localparam int unsigned ADDR_W       = 17;
  localparam int unsigned NUM_SRC      = 30;
  localparam int unsigned SLOT_W       = 5;
  localparam int unsigned SLOT_WORDS   = 2;
  localparam logic [16:0] RESET_ADDR   = 17'h00000;
  localparam logic [16:0] FLASH_START  = 17'h00000;
  localparam logic        FUSE_RESET   = 1'b1;
  localparam logic [16:0] TABLE_OFFSET = 17'h00002;
  localparam logic [16:0] BOOT_START   = 17'h1f000;
  // vector change window length in cycles
  localparam int unsigned CHANGE_WINDOW = 4;
  localparam logic [2:0]  CHANGE_CNT_W  = 3'h4;
  localparam logic        SELECT_RESET  = 1'b0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              valid;
    logic [SLOT_W-1:0] slot;
  } ivg_vector_type;

  typedef enum logic [1:0] {
    IVG_IDLE   = 2'b01,
    IVG_CHANGE = 2'b10
  } ivg_state_type;
endpackage
`default_nettype wire

// [verilog/ivg_vector_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module ivg_vector_gen #(
  parameter logic [16:0] BOOT_RESET_ADDR = ivg_pkg::BOOT_START
) (
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_resetn,
  // fuse and core control register write port
  input  wire logic                        i_boot_reset_select_fuse,
  input  wire logic                        i_ctrl_write,
  input  wire logic                        i_vector_table_select,
  input  wire logic                        i_vector_change_enable,
  input  wire logic                        i_instr_done,
  // requests, bit n is slot n+2
  input  wire logic [ivg_pkg::NUM_SRC-1:0] i_request,
  input  wire logic                        i_global_enable,
  // core fetch side
  input  wire logic                        i_ack,
  output logic      [ivg_pkg::ADDR_W-1:0]  o_reset_addr,
  output logic                             o_irq,
  output var ivg_pkg::ivg_vector_type      o_vector,
  output logic                             o_vector_table_select,
  output logic                             o_vector_change_enable,
  output logic                             o_irq_blocked
);
  // elaboration checks on settings the logic cannot serve
  if (ivg_pkg::NUM_SRC + 1 > (1 << ivg_pkg::SLOT_W)) begin : g_slot_width
    $error("slot width too small for source count");
  end
  if (BOOT_RESET_ADDR[0] != 1'b0) begin : g_boot_align
    $error("boot reset address must sit on a slot boundary");
  end
  if (32'(BOOT_RESET_ADDR) + ivg_pkg::SLOT_WORDS * (ivg_pkg::NUM_SRC + 1)
      > (32'h1 << ivg_pkg::ADDR_W)) begin : g_boot_fit
    $error("relocated table runs past the top of program memory");
  end
  if (ivg_pkg::SLOT_WORDS != 32'(ivg_pkg::TABLE_OFFSET)) begin : g_table_start
    $error("table start must be one slot above the reset slot");
  end
  if (ivg_pkg::CHANGE_WINDOW != 32'(ivg_pkg::CHANGE_CNT_W)) begin : g_window
    $error("change window length does not match its counter preset");
  end

  ivg_pkg::ivg_state_type state_reg, state_next;
  logic [2:0]             cnt_reg, cnt_next;
  logic                   sel_reg, sel_next;
  logic                   hold_reg, hold_next;
  logic                   fuse_reg, fuse_next;
  logic                   fuse_valid_reg, fuse_valid_next;
  ivg_pkg::ivg_vector_type vec_reg, vec_next;
  logic                   blocked;
  logic [16:0]            base;
  logic [16:0]            slot_off;
  logic [ivg_pkg::SLOT_W-1:0] slot_num;
  logic [ivg_pkg::SLOT_W-1:0] win;
  logic                   found;

  // fuse caught after reset release; reset address follows fuse only
  always_comb begin
    fuse_next       = fuse_valid_reg ? fuse_reg : i_boot_reset_select_fuse;
    fuse_valid_next = 1'b1;
  end

  // select change sequence
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sel_next   = sel_reg;
    hold_next  = hold_reg && !i_instr_done;
    unique case (state_reg)
      ivg_pkg::IVG_IDLE: begin
        if (i_ctrl_write && i_vector_change_enable) begin
          state_next = ivg_pkg::IVG_CHANGE;
          cnt_next   = ivg_pkg::CHANGE_CNT_W;
        end
      end
      ivg_pkg::IVG_CHANGE: begin
        cnt_next = cnt_reg - 3'h1;
        if (i_ctrl_write && !i_vector_change_enable) begin
          sel_next   = i_vector_table_select;
          hold_next  = 1'b1;
          state_next = ivg_pkg::IVG_IDLE;
        end else if (cnt_reg == 3'h1) begin
          state_next = ivg_pkg::IVG_IDLE;
        end
      end
    endcase
  end

  // block also through the instruction following the select write
  assign blocked = (state_reg == ivg_pkg::IVG_CHANGE) || hold_reg ||
                   (i_ctrl_write && i_vector_change_enable);

  // region start follows select only; slot 2 sits one slot above it
  assign base = sel_reg ? BOOT_RESET_ADDR
                        : ivg_pkg::FLASH_START;

  // lowest index wins; index order matches slot order
  always_comb begin
    win   = '0;
    found = 1'b0;
    for (int i = ivg_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (i_request[i]) begin
        win   = ivg_pkg::SLOT_W'(i);
        found = 1'b1;
      end
    end
  end

  // source index to vector number; codes above 5'h1d never win
  always_comb begin
    unique case (win)
      // external requests
      5'h00: slot_num = 5'h02; // ext_request_0
      5'h01: slot_num = 5'h03; // ext_request_1
      5'h02: slot_num = 5'h04; // ext_request_2
      // pin change and watchdog requests
      5'h03: slot_num = 5'h05; // pin_change_request_0
      5'h04: slot_num = 5'h06; // pin_change_request_1
      5'h05: slot_num = 5'h07; // pin_change_request_2
      5'h06: slot_num = 5'h08; // pin_change_request_3
      5'h07: slot_num = 5'h09; // watchdog_timeout_request
      // 8-bit timer two
      5'h08: slot_num = 5'h0a; // timer_two_compare_a
      5'h09: slot_num = 5'h0b; // timer_two_compare_b
      5'h0a: slot_num = 5'h0c; // timer_two_overflow
      // 16-bit timer one
      5'h0b: slot_num = 5'h0d; // timer_one_capture
      5'h0c: slot_num = 5'h0e; // timer_one_compare_a
      5'h0d: slot_num = 5'h0f; // timer_one_compare_b
      5'h0e: slot_num = 5'h10; // timer_one_overflow
      // timer zero and serial peripheral
      5'h0f: slot_num = 5'h11; // timer_zero_compare_a
      5'h10: slot_num = 5'h12; // timer_zero_compare_b
      5'h11: slot_num = 5'h13; // timer_zero_overflow
      5'h12: slot_num = 5'h14; // serial_periph_done
      // first uart
      5'h13: slot_num = 5'h15; // uart0_rx_done
      5'h14: slot_num = 5'h16; // uart0_tx_buffer_empty
      5'h15: slot_num = 5'h17; // uart0_tx_done
      // analog, memory and two-wire sources
      5'h16: slot_num = 5'h18; // analog_compare
      5'h17: slot_num = 5'h19; // adc_done
      5'h18: slot_num = 5'h1a; // eeprom_ready_request
      5'h19: slot_num = 5'h1b; // two_wire_serial
      5'h1a: slot_num = 5'h1c; // self_program_ready
      // second uart
      5'h1b: slot_num = 5'h1d; // uart1_rx_done
      5'h1c: slot_num = 5'h1e; // uart1_tx_buffer_empty
      5'h1d: slot_num = 5'h1f; // uart1_tx_done
      default: slot_num = 5'h00;
    endcase
  end

  // slot n sits two words per slot above the region start, slot 1 at zero
  assign slot_off = 17'(ivg_pkg::SLOT_WORDS * (slot_num - 5'h01));

  // vector hold: latched until acknowledged
  always_comb begin
    vec_next = vec_reg;
    if (vec_reg.valid) begin
      if (i_ack) begin
        vec_next.valid = 1'b0;
      end
    end else if (found && i_global_enable && !blocked) begin
      vec_next.valid = 1'b1;
      vec_next.addr  = base + slot_off;
      vec_next.slot  = slot_num;
    end
  end

  // fuse capture
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fuse_reg       <= ivg_pkg::FUSE_RESET;
      fuse_valid_reg <= 1'b0;
    end else begin
      fuse_reg       <= fuse_next;
      fuse_valid_reg <= fuse_valid_next;
    end
  end

  // select change sequence
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ivg_pkg::IVG_IDLE;
      cnt_reg   <= 3'h0;
      sel_reg   <= ivg_pkg::SELECT_RESET;
      hold_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sel_reg   <= sel_next;
      hold_reg  <= hold_next;
    end
  end

  // vector hold
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      vec_reg <= '0;
    end else begin
      vec_reg <= vec_next;
    end
  end

  // fuse 1 unprogrammed -> address zero, slot 1
  assign o_reset_addr = fuse_reg ? ivg_pkg::RESET_ADDR : BOOT_RESET_ADDR;
  assign o_vector               = vec_reg;
  assign o_irq                  = vec_reg.valid;
  assign o_vector_table_select  = sel_reg;
  assign o_vector_change_enable = (state_reg == ivg_pkg::IVG_CHANGE);
  assign o_irq_blocked          = blocked;
endmodule
`default_nettype wire

// [verification/ivg_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ivg_core_model (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // fetch side
  input  wire logic       i_irq,
  input  wire logic [3:0] i_delay,
  output var  logic       o_ack
);
  logic [3:0] wait_reg;
  // one ack pulse per vector, after i_delay idle cycles
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_reg <= 4'h0;
      o_ack    <= 1'b0;
    end else begin
      o_ack    <= i_irq && !o_ack && wait_reg == i_delay;
      wait_reg <= (i_irq && !o_ack && wait_reg != i_delay) ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// [verification/ivg_vector_gen_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module ivg_vector_gen_assertions #(
  parameter logic [16:0] BOOT_RESET_ADDR = 17'h1f000
) (
  // clock, reset and inputs
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        i_boot_reset_select_fuse,
  input wire logic        i_ctrl_write,
  input wire logic        i_vector_table_select,
  input wire logic        i_vector_change_enable,
  input wire logic        i_instr_done,
  input wire logic [29:0] i_request,
  input wire logic        i_global_enable,
  input wire logic        i_ack,
  // outputs
  input wire logic [16:0] o_reset_addr,
  input wire logic        o_irq,
  input wire ivg_pkg::ivg_vector_type o_vector,
  input wire logic        o_vector_table_select,
  input wire logic        o_vector_change_enable,
  input wire logic        o_irq_blocked
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic sel_wr;
  assign sel_wr = o_vector_change_enable && i_ctrl_write && !i_vector_change_enable;
  a_reset_addr: assert property ($past(i_resetn) |-> o_reset_addr ==
    (i_boot_reset_select_fuse ? 17'h0 : BOOT_RESET_ADDR)) else $error("reset address wrong");
  a_vector_addr: assert property (o_irq |-> o_vector.addr ==
    (o_vector_table_select ? BOOT_RESET_ADDR : 17'h0) + 17'h2 * 17'(o_vector.slot - 5'h1))
    else $error("vector address wrong");
  a_lowest_first: assert property ($rose(o_irq) |->
    ($past(i_request) & ((30'h2 << (o_vector.slot - 5'h2)) - 30'h1)) ==
    (30'h1 << (o_vector.slot - 5'h2))) else $error("slot is not lowest pending");
  a_ack_drops: assert property (o_irq && i_ack |=> !o_irq) else $error("irq held after ack");
  a_vec_stands: assert property (o_irq && !i_ack |=> o_irq && $stable(o_vector))
    else $error("vector changed before ack");
  a_take_refused: assert property (!o_irq &&
    (o_irq_blocked || !i_global_enable) |=> !o_irq) else $error("vector taken while refused");
  a_block_start: assert property (i_ctrl_write && i_vector_change_enable |->
    o_irq_blocked) else $error("not blocked on change enable");
  a_hold_after: assert property (sel_wr |=> o_irq_blocked)
    else $error("not blocked after select write");
  a_hold_release: assert property (o_irq_blocked && !o_vector_change_enable &&
    !i_ctrl_write && i_instr_done |=> o_irq_blocked == (i_ctrl_write && i_vector_change_enable))
    else $error("block held past instruction end");
  a_window_len: assert property ($rose(o_vector_change_enable) |->
    ##[1:4] !o_vector_change_enable) else $error("change window too long");
  a_select_load: assert property (sel_wr |=>
    o_vector_table_select == $past(i_vector_table_select)) else $error("select not loaded");
  a_select_hold: assert property (!sel_wr |=> $stable(o_vector_table_select))
    else $error("select changed outside sequence");
  cover property ($rose(o_irq));
  cover property (sel_wr);
  cover property ($fell(o_vector_change_enable));
  cover property (o_irq && o_vector_table_select);
endmodule
bind ivg_vector_gen ivg_vector_gen_assertions #(.BOOT_RESET_ADDR(BOOT_RESET_ADDR))
  ivg_vector_gen_assertions_inst (.*);
`default_nettype wire

// [verification/ivg_vector_gen_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module ivg_vector_gen_bench;
  localparam logic [16:0] BOOT = 17'h1e000;
  logic clk = 1'b0, resetn = 1'b0, fuse = 1'b1, wr = 1'b0, sel = 1'b0, vce = 1'b0, ge = 1'b1;
  logic [29:0] req = '0;
  logic [3:0] dly = 4'h0;
  logic idone = 1'b1;
  logic [16:0] raddr;
  logic ack, irq, osel, ovce, blk;
  ivg_pkg::ivg_vector_type vec;
  int n_mismatch = 0, n_checks = 0;
  always #50 clk = ~clk;
  ivg_vector_gen #(.BOOT_RESET_ADDR(BOOT)) ivg_vector_gen_inst (.i_clk(clk), .i_resetn(resetn),
    .i_boot_reset_select_fuse(fuse), .i_ctrl_write(wr), .i_vector_table_select(sel),
    .i_vector_change_enable(vce), .i_instr_done(idone), .i_request(req), .i_global_enable(ge),
    .i_ack(ack), .o_reset_addr(raddr), .o_irq(irq), .o_vector(vec),
    .o_vector_table_select(osel), .o_vector_change_enable(ovce), .o_irq_blocked(blk));
  ivg_core_model ivg_core_model_inst (.i_clk(clk), .i_resetn(resetn), .i_irq(irq),
    .i_delay(dly), .o_ack(ack));
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_lvl(input logic v);
    for (int i = 0; i < 20 && irq !== v; i++) @(negedge clk);
    if (irq !== v) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  task automatic do_reset(input logic f);
    @(posedge clk) begin resetn <= 1'b0; fuse <= f; end
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(negedge clk);
  endtask
  task automatic serve(input int b, input logic [16:0] base);
    @(posedge clk) begin req <= 30'h1 << b; dly <= 4'(b % 3); end
    wait_lvl(1'b1);
    chk(vec.addr, base + 17'(2 * b));
    chk(vec.slot, b + 2);
    @(posedge clk) req <= '0;
    wait_lvl(1'b0);
  endtask
  task automatic t_prio;
    @(posedge clk) begin ge <= 1'b0; req <= 30'h20000020; end
    repeat (3) @(negedge clk);
    chk(irq, 1'b0);
    @(posedge clk) ge <= 1'b1;
    wait_lvl(1'b1);
    chk(vec.slot, 5'h7);
    @(posedge clk) req <= '0;
    wait_lvl(1'b0);
  endtask
  task automatic t_select;
    @(posedge clk) begin wr <= 1'b1; vce <= 1'b1; sel <= 1'b1; end
    @(negedge clk) chk(blk, 1'b1);
    @(posedge clk) wr <= 1'b0;
    @(negedge clk) chk(ovce, 1'b1);
    repeat (4) @(negedge clk);
    chk({ovce, osel}, 2'h0);
    @(posedge clk) wr <= 1'b1;
    @(posedge clk) begin vce <= 1'b0; idone <= 1'b0; end
    @(posedge clk) wr <= 1'b0;
    @(negedge clk) chk(osel, 1'b1);
    chk(blk, 1'b1);
    repeat (2) @(negedge clk);
    chk(blk, 1'b1);
    @(posedge clk) idone <= 1'b1;
    serve(29, BOOT + 17'h2);
    chk(raddr, 17'h0);
  endtask
  initial begin
    do_reset(1'b1);
    chk(raddr, 17'h0);
    for (int b = 0; b < 30; b++) serve(b, 17'h2);
    t_prio();
    t_select();
    do_reset(1'b0);
    chk(raddr, BOOT);
    serve(0, 17'h2);
    give_verdict();
  end
endmodule
`default_nettype wire
